/* File: tsilb_pkg.sv */
package tsilb_pkg;

  // Slot geometry: depths in 8.192 Mbit/s slot periods, the rest in bits.
  localparam int          SLOT_W        = 7;
  localparam int          FRAME_SLOTS   = 128;
  localparam int          HIST_W        = 9;
  localparam int          HIST_DEPTH    = 512;
  localparam int          DATA_W        = 8;
  localparam int          STREAM_W      = 5;

  // Connection entry layout.
  localparam int          ENT_W         = 10;
  localparam int          ENT_FROM_LSB  = 0;
  localparam int          ENT_BSEL      = 7;
  localparam int          ENT_STRNEG    = 8;
  localparam int          ENT_VALID     = 9;

  // Connection control bits.
  localparam int          CTRL_GLOBAL   = 0;
  localparam int          CTRL_OVERRIDE = 1;

  // Latency figures.
  localparam logic [8:0]  LAT_ONE_FRAME = 9'h080;
  localparam logic [8:0]  LAT_TWO_FRAME = 9'h100;
  localparam logic [8:0]  LAT_EXC_257   = 9'h101;
  localparam logic [8:0]  LAT_EXC_258   = 9'h102;
  localparam logic [8:0]  LAT_EXC_2     = 9'h002;

  // Slot deltas with special handling.
  localparam logic signed [7:0] TSD_P1  = 8'sh01;
  localparam logic signed [7:0] TSD_P2  = 8'sh02;
  localparam logic signed [7:0] TSD_M126 = -8'sh7E;
  localparam logic signed [7:0] TSD_M127 = -8'sh7F;

  // Stream rate codes; the code is also the left shift into 8.192 Mbit/s slots.
  typedef enum logic [1:0] {
    TSILB_RATE_8192 = 2'b00,
    TSILB_RATE_4096 = 2'b01,
    TSILB_RATE_2048 = 2'b10
  } tsilb_rate_t;

endpackage

/* File: tsilb_mem.sv */
`timescale 1ns/1ps
module tsilb_mem #(
  parameter int WIDTH  = 8,
  parameter int ADDR_W = 9
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [WIDTH-1:0]  wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [WIDTH-1:0]  rdata
);

  logic [WIDTH-1:0] store [0:(1<<ADDR_W)-1];

  // The array has no reset so that it maps onto plain RAM.
  always_ff @(posedge clock) begin
    if (we) begin
      store[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= store[raddr];
    end
  end

endmodule

/* File: tsilb_top.sv */
`timescale 1ns/1ps
module tsilb_top (
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire logic                           slot_tick,
  input  wire logic [tsilb_pkg::DATA_W-1:0]   in_data,
  input  wire logic [1:0]                     connection_control_reg,
  input  wire logic                           cfg_we,
  input  wire logic [tsilb_pkg::SLOT_W-1:0]   cfg_to_slot,
  input  wire logic [tsilb_pkg::STREAM_W-1:0] cfg_to_stream,
  input  wire logic [tsilb_pkg::SLOT_W-1:0]   cfg_from_slot,
  input  wire logic [tsilb_pkg::STREAM_W-1:0] cfg_from_stream,
  input  wire logic [1:0]                     cfg_rate,
  input  wire logic                           cfg_buffer_select_bit,
  input  wire logic                           cfg_valid,
  output logic                                out_valid,
  output logic      [tsilb_pkg::SLOT_W-1:0]   out_slot,
  output logic      [tsilb_pkg::DATA_W-1:0]   out_data,
  output logic      [8:0]                     out_latency
);

  // Latency in slot periods for one connection. The exceptions come from the
  // pipeline meeting the buffer swap, so they are matched before the linear parts.
  function automatic logic [8:0] slot_latency(input logic signed [7:0] d,
                                              input logic              bsel,
                                              input logic              str_neg);
    logic [8:0] dz;
    dz = {d[7], d};
    if (!bsel) begin
      // Forward deltas give minimum delay here, reverse deltas constant delay.
      if (d == tsilb_pkg::TSD_P1) begin
        slot_latency = tsilb_pkg::LAT_EXC_257;
      end else if (d == tsilb_pkg::TSD_P2) begin
        slot_latency = str_neg ? tsilb_pkg::LAT_EXC_258 : tsilb_pkg::LAT_EXC_2;
      end else if (!d[7] && d != 8'sh00) begin
        slot_latency = dz;
      end else begin
        slot_latency = tsilb_pkg::LAT_TWO_FRAME + dz;
      end
    end else begin
      if (d == tsilb_pkg::TSD_M127) begin
        slot_latency = tsilb_pkg::LAT_EXC_257;
      end else if (d == tsilb_pkg::TSD_M126) begin
        slot_latency = str_neg ? tsilb_pkg::LAT_EXC_258 : tsilb_pkg::LAT_EXC_2;
      end else begin
        // Forward deltas give constant delay here, reverse deltas minimum delay.
        slot_latency = tsilb_pkg::LAT_ONE_FRAME + dz;
      end
    end
  endfunction

  // Connection table write path.
  logic [tsilb_pkg::SLOT_W-1:0] to8;
  logic [tsilb_pkg::SLOT_W-1:0] from8;
  logic [tsilb_pkg::ENT_W-1:0]  ent_wdata;
  logic [tsilb_pkg::ENT_W-1:0]  ent_rdata;

  // Shifting into the 7-bit 8.192 Mbit/s slot space drops nothing for legal slots.
  always_comb begin
    to8   = tsilb_pkg::SLOT_W'(cfg_to_slot << cfg_rate);
    from8 = tsilb_pkg::SLOT_W'(cfg_from_slot << cfg_rate);
    ent_wdata = '0;
    ent_wdata[tsilb_pkg::ENT_FROM_LSB +: tsilb_pkg::SLOT_W] = from8;
    ent_wdata[tsilb_pkg::ENT_BSEL]   = cfg_buffer_select_bit;
    ent_wdata[tsilb_pkg::ENT_STRNEG] = cfg_to_stream < cfg_from_stream;
    ent_wdata[tsilb_pkg::ENT_VALID]  = cfg_valid;
  end

  // Stage 1 lookup: select bit, slot delta, latency and history address.
  logic                         eff_bsel;
  logic signed [7:0]            delta;
  logic [8:0]                   lat;
  logic [tsilb_pkg::HIST_W-1:0] rd_addr;
  logic [tsilb_pkg::DATA_W-1:0] hist_rdata;

  // Slot counter and stage 1 state.
  logic [tsilb_pkg::HIST_W-1:0] slot_abs;
  logic [tsilb_pkg::HIST_W-1:0] s1_abs;
  logic                         s1_tick;
  logic [tsilb_pkg::HIST_W-1:0] next_slot_abs;
  logic [tsilb_pkg::HIST_W-1:0] next_s1_abs;
  logic                         next_s1_tick;

  // Stage 2 state, waiting for the history read.
  logic                         s2_tick;
  logic                         s2_valid;
  logic [tsilb_pkg::SLOT_W-1:0] s2_slot;
  logic [8:0]                   s2_lat;
  logic                         next_s2_tick;
  logic                         next_s2_valid;
  logic [tsilb_pkg::SLOT_W-1:0] next_s2_slot;
  logic [8:0]                   next_s2_lat;

  // Output stage state.
  logic                         next_out_valid;
  logic [tsilb_pkg::SLOT_W-1:0] next_out_slot;
  logic [tsilb_pkg::DATA_W-1:0] next_out_data;
  logic [8:0]                   next_out_latency;

  always_comb begin
    // A set override bit replaces every per-connection select bit.
    eff_bsel = connection_control_reg[tsilb_pkg::CTRL_OVERRIDE]
             ? connection_control_reg[tsilb_pkg::CTRL_GLOBAL]
             : ent_rdata[tsilb_pkg::ENT_BSEL];
    delta = $signed({1'b0, s1_abs[tsilb_pkg::SLOT_W-1:0]})
          - $signed({1'b0, ent_rdata[tsilb_pkg::ENT_FROM_LSB +: tsilb_pkg::SLOT_W]});
    lat = slot_latency(delta, eff_bsel, ent_rdata[tsilb_pkg::ENT_STRNEG]);
    // History holds four frames, so reading back by the latency always lands in
    // the buffer the input was captured into, whichever frame that was.
    rd_addr = s1_abs - lat;
  end

  // The counter keeps absolute slots modulo the history depth; its low bits
  // name the output slot, so table read and history write share one count.
  always_comb begin
    next_slot_abs = slot_tick ? slot_abs + 9'h001 : slot_abs;
    next_s1_abs   = slot_tick ? slot_abs : s1_abs;
    next_s1_tick  = slot_tick;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slot_abs <= '0;
      s1_abs   <= '0;
      s1_tick  <= 1'b0;
    end else begin
      slot_abs <= next_slot_abs;
      s1_abs   <= next_s1_abs;
      s1_tick  <= next_s1_tick;
    end
  end

  // The latency is kept for every tick so out_latency follows disabled slots too,
  // while only a valid entry lets the delivery through.
  always_comb begin
    next_s2_tick  = s1_tick;
    next_s2_valid = s1_tick & ent_rdata[tsilb_pkg::ENT_VALID];
    next_s2_slot  = s1_tick ? s1_abs[tsilb_pkg::SLOT_W-1:0] : s2_slot;
    next_s2_lat   = s1_tick ? lat : s2_lat;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s2_tick  <= 1'b0;
      s2_valid <= 1'b0;
      s2_slot  <= '0;
      s2_lat   <= '0;
    end else begin
      s2_tick  <= next_s2_tick;
      s2_valid <= next_s2_valid;
      s2_slot  <= next_s2_slot;
      s2_lat   <= next_s2_lat;
    end
  end

  // out_slot and out_latency hold between ticks and out_data between deliveries, so a
  // slow reader still sees a settled slot; a disabled slot leaves the last delivered byte in place.
  always_comb begin
    next_out_valid   = s2_tick & s2_valid;
    next_out_slot    = s2_tick ? s2_slot : out_slot;
    next_out_data    = (s2_tick & s2_valid) ? hist_rdata : out_data;
    next_out_latency = s2_tick ? s2_lat : out_latency;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_valid   <= 1'b0;
      out_slot    <= '0;
      out_data    <= '0;
      out_latency <= '0;
    end else begin
      out_valid   <= next_out_valid;
      out_slot    <= next_out_slot;
      out_data    <= next_out_data;
      out_latency <= next_out_latency;
    end
  end

  // The table is indexed by output slot, so each output slot has one source.
  tsilb_mem #(
    .WIDTH  (tsilb_pkg::ENT_W),
    .ADDR_W (tsilb_pkg::SLOT_W)
  ) u_conn_table (
    .clock (clock),
    .rst   (rst),
    .we    (cfg_we),
    .waddr (to8),
    .wdata (ent_wdata),
    .raddr (slot_abs[tsilb_pkg::SLOT_W-1:0]),
    .rdata (ent_rdata)
  );

  // Four frames of history cover the longest latency without a buffer swap
  // ever overwriting a byte that is still waiting to be delivered.
  tsilb_mem #(
    .WIDTH  (tsilb_pkg::DATA_W),
    .ADDR_W (tsilb_pkg::HIST_W)
  ) u_history (
    .clock (clock),
    .rst   (rst),
    .we    (slot_tick),
    .waddr (slot_abs),
    .wdata (in_data),
    .raddr (rd_addr),
    .rdata (hist_rdata)
  );

endmodule

/* File: tsilb_top_assertions.sv */
`timescale 1ns/1ps
module tsilb_top_assertions (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       slot_tick,
  input wire logic [1:0] connection_control_reg,
  input wire logic       out_valid,
  input wire logic [6:0] out_slot,
  input wire logic [7:0] out_data,
  input wire logic [8:0] out_latency
);
  logic [6:0] tick_cnt;
  logic [6:0] next_tick_cnt;
  always_comb next_tick_cnt = slot_tick ? tick_cnt + 7'h01 : tick_cnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      tick_cnt <= 7'h00;
    else
      tick_cnt <= next_tick_cnt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_valid_after_tick: assert property (out_valid |-> $past(slot_tick, 3))
    else $error("out_valid without a tick three cycles before");
  a_slot_from_count: assert property (out_valid |-> out_slot == $past(tick_cnt, 3))
    else $error("out_slot differs from the ticked slot");
  a_valid_one_cycle: assert property (out_valid |=> !out_valid)
    else $error("out_valid longer than one cycle");
  a_latency_bounds: assert property (out_valid |-> out_latency >= 9'h002 && out_latency <= 9'h102)
    else $error("latency outside 2 to 258");
  a_linear_window: assert property (out_valid && $past(connection_control_reg, 2) == 2'h3
    |-> out_latency inside {[9'h003:9'h0FF], 9'h002, 9'h101, 9'h102})
    else $error("latency off the linear mapping");
  a_mixed_no_frame: assert property (out_valid && $past(connection_control_reg, 2) == 2'h2
    |-> out_latency != 9'h080)
    else $error("latency of one frame under mixed delay");
  a_data_held: assert property ($changed(out_data) |-> out_valid)
    else $error("out_data changed without out_valid");
  a_quiet_after_reset: assert property ($fell(rst) |-> !out_valid [*3])
    else $error("out_valid too soon after reset");
  c_exc_257: cover property (out_valid && out_latency == 9'h101);
  c_exc_258: cover property (out_valid && out_latency == 9'h102);
  c_exc_2: cover property (out_valid && out_latency == 9'h002);
endmodule
bind tsilb_top tsilb_top_assertions tsilb_top_assertions_i (.clock, .rst, .slot_tick, .connection_control_reg,
  .out_valid, .out_slot, .out_data, .out_latency);

/* File: tsilb_stream_src.sv */
`timescale 1ns/1ps
module tsilb_stream_src (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       run,
  output logic            slot_tick,
  output logic      [7:0] in_data
);
  // Ticks stand still while halted so the table can be rewritten between frames.
  int phase;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= 0;
      slot_tick <= 1'b0;
      in_data <= 8'h00;
    end else begin
      phase <= run ? (phase + 1) % 8 : 0;
      slot_tick <= run && phase == 7;
      in_data <= in_data * 8'h05 + 8'h3B;
    end
  end
endmodule

/* File: tb_tsi_latency_buffer_select.sv */
`timescale 1ns/1ps
module tb_tsi_latency_buffer_select;
  typedef struct {bit t; bit v; int slot; int lat; int dat;} tsilb_exp_t;
  logic       clock = 0, rst = 1, run = 0, slot_tick, cfg_we = 0, cfg_buffer_select_bit = 0, cfg_valid = 0;
  logic [7:0] in_data, out_data;
  logic [1:0] connection_control_reg = 0, cfg_rate = 0;
  logic [6:0] cfg_to_slot = 0, cfg_from_slot = 0, out_slot;
  logic [4:0] cfg_to_stream = 0, cfg_from_stream = 0;
  logic       out_valid;
  logic [8:0] out_latency;
  int         err_total = 0, comparisons = 0, seed = 93, abs_slot = 0, s, d, b;
  int         ent_from[128], hist[4096];
  bit         ent_b[128], ent_neg[128], ent_v[128];
  tsilb_exp_t st[3];
  always #2.5 clock = ~clock;
  tsilb_stream_src tsilb_stream_src_i (.clock, .rst, .run, .slot_tick, .in_data);
  tsilb_top tsilb_top_i (.clock, .rst, .slot_tick, .in_data, .connection_control_reg, .cfg_we, .cfg_to_slot,
    .cfg_to_stream, .cfg_from_slot, .cfg_from_stream, .cfg_rate, .cfg_buffer_select_bit, .cfg_valid,
    .out_valid, .out_slot, .out_data, .out_latency);
  function automatic int lat_of(int d, int b, bit neg);
    if (b == 0) begin
      if (d == 1) return 257;
      if (d == 2) return neg ? 258 : 2;
      return d >= 3 ? d : 256 + d;
    end
    if (d == -127) return 257;
    if (d == -126) return neg ? 258 : 2;
    return 128 + d;
  endfunction
  task automatic check(string name, logic [8:0] seen, int exp);
    comparisons++;
    if (seen !== 9'(exp)) begin
      err_total++;
      $display("mismatch %s expected %0d seen %0d", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Entries 0 to 3 sit on the pipeline exception deltas; every fourth entry from entry 4 on draws a random rate code from 0 to 2.
  task automatic write_entry(input int i);
    int r, rt;
    r = $random(seed);
    rt = (i % 4 == 0 && i >= 4) ? (r & 32'hFF) % 3 : 0;
    cfg_we <= 1'b1;
    cfg_rate <= 2'(rt);
    cfg_to_slot <= 7'(i >> rt);
    cfg_from_slot <= i < 4 ? (i < 2 ? 7'h7F : 7'h01) : 7'((r >> 16) & (127 >> rt));
    cfg_from_stream <= 5'(r >> 8);
    cfg_to_stream <= 5'(r >> 8) ^ (r[3] ? 5'h01 : 5'h10);
    cfg_buffer_select_bit <= r[4];
    cfg_valid <= i < 4 || r[7:5] != 3'h0;
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (rst) begin
      st[0].t = 0;
      st[1].t = 0;
      st[2].t = 0;
    end else begin
      check("out_valid", 9'(out_valid), st[2].t && st[2].v);
      if (st[2].t && st[2].v) begin
        check("out_slot", 9'(out_slot), st[2].slot);
        check("out_latency", out_latency, st[2].lat);
        if (st[2].dat >= 0) check("out_data", 9'(out_data), st[2].dat);
      end
      st[2] = st[1];
      st[1] = st[0];
      st[0] = '{0, 0, 0, 0, -1};
      if (cfg_we) begin
        s = (int'(cfg_to_slot) << cfg_rate) % 128;
        ent_from[s] = (int'(cfg_from_slot) << cfg_rate) % 128;
        ent_b[s] = cfg_buffer_select_bit;
        ent_neg[s] = cfg_to_stream < cfg_from_stream;
        ent_v[s] = cfg_valid;
      end
      if (slot_tick) begin
        s = abs_slot % 128;
        hist[abs_slot] = in_data;
        b = connection_control_reg[1] ? connection_control_reg[0] : ent_b[s];
        d = s - ent_from[s];
        st[0] = '{1, ent_v[s], s, lat_of(d, b, ent_neg[s]), -1};
        if (abs_slot >= st[0].lat) st[0].dat = hist[abs_slot - st[0].lat];
        abs_slot++;
      end
    end
  end
  initial begin
    #80000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      run <= 1'b0;
      repeat (12) @(posedge clock);
      connection_control_reg <= 2'(p);
      for (int i = 0; i < 128; i++) write_entry(i);
      cfg_we <= 1'b0;
      run <= 1'b1;
      repeat (2400) @(posedge clock);
    end
    give_verdict();
  end
endmodule
